// ===== hw/itc_ctrl.sv
// Purpose: control/status of eight isochronous transmit DMA contexts
// Assumes: descriptor engine drives the per-context event inputs
//          synchronously, one-cycle pulses
// Notes:   register port with read data in the cycle after the strobe
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module itc_ctrl
   import itc_pkg::*;
(
   input  wire logic                 i_mclk,
   input  wire logic                 i_arst_n,
   input  wire logic                 i_soft_rst,
   input  wire logic [ITC_AW-1:0]    i_addr,
   input  wire logic [ITC_DW-1:0]    i_wdata,
   input  wire logic                 i_wr,
   input  wire logic                 i_rd,
   output logic      [ITC_DW-1:0]    o_rdata,
   input  wire logic                 i_cs_valid,
   input  wire logic [6:0]           i_cs_seconds,
   input  wire logic [12:0]          i_cs_count,
   input  wire logic [ITC_NCTX-1:0]  i_desc_fetch,
   input  wire logic [ITC_NCTX-1:0]  i_list_done,
   input  wire logic [ITC_NCTX-1:0]  i_fatal_err,
   input  wire logic                 i_evt_valid,
   input  wire logic [2:0]           i_evt_ctx,
   input  wire logic [4:0]           i_evt_code,
   output logic      [ITC_NCTX-1:0]  o_fetch_en,
   output logic      [ITC_NCTX-1:0]  o_tx_en,
   output logic                      o_irq
);

   // address decode shared by read and write paths
   function automatic logic ctx_hit(input logic [ITC_AW-1:0] a,
                                    input logic [ITC_AW-1:0] base);
      ctx_hit = ((a & ITC_CTX_MASK) == base);
   endfunction

   function automatic itc_idx_t ctx_of(input logic [ITC_AW-1:0] a);
      ctx_of = a[ITC_CTX_LSB +: ITC_CTX_W];
   endfunction

   logic                soc_en_reg  [ITC_NCTX];
   logic [ITC_TGT_W-1:0] tgt_reg    [ITC_NCTX];
   logic                run_reg     [ITC_NCTX];
   logic                wake_reg    [ITC_NCTX];
   logic                dead_reg    [ITC_NCTX];
   logic                active_reg  [ITC_NCTX];
   logic                paused_reg  [ITC_NCTX];
   logic                hold_reg    [ITC_NCTX];
   logic [ITC_EVT_W-1:0] evt_reg    [ITC_NCTX];

   logic                soc_en_next [ITC_NCTX];
   logic [ITC_TGT_W-1:0] tgt_next   [ITC_NCTX];
   logic                run_next    [ITC_NCTX];
   logic                wake_next   [ITC_NCTX];
   logic                dead_next   [ITC_NCTX];
   logic                active_next [ITC_NCTX];
   logic                paused_next [ITC_NCTX];
   logic                hold_next   [ITC_NCTX];
   logic [ITC_EVT_W-1:0] evt_next   [ITC_NCTX];

   logic [15:0]         stat_reg;
   logic [15:0]         stat_next;
   logic [15:0]         mask_reg;
   logic [15:0]         mask_next;
   logic [ITC_DW-1:0]   rdata_reg;
   logic [ITC_DW-1:0]   rdata_next;

   wire logic     set_hit  = ctx_hit(i_addr, ITC_SET_BASE);
   wire logic     clr_hit  = ctx_hit(i_addr, ITC_CLR_BASE);
   wire itc_idx_t acc_ctx  = ctx_of(i_addr);
   wire logic     stat_hit = (i_addr == ITC_IRQ_STAT);
   wire logic     mask_hit = (i_addr == ITC_IRQ_MASK);

   // cycle number of the latest cycle start: 2 seconds bits, 13 count
   wire logic [ITC_TGT_W-1:0] cs_cycle =
      {i_cs_seconds[ITC_SEC_W-1:0], i_cs_count};

   // per-context target hit on the cycle start of this cycle
   logic [ITC_NCTX-1:0] tgt_match;

   always_comb
   begin
      for (int n = 0; n < ITC_NCTX; n++)
      begin
         tgt_match[n] = i_cs_valid && (cs_cycle == tgt_reg[n]);
      end
   end

   // combined control word of the addressed context
   function automatic logic [ITC_DW-1:0] ctl_word(input itc_idx_t n);
      logic [ITC_DW-1:0] w;
      w = ITC_ZERO32;
      w[ITC_B_SOC_EN] = soc_en_reg[n];
      w[ITC_B_TGT_HI:ITC_B_TGT_LO] = tgt_reg[n];
      w[ITC_B_RUN]    = run_reg[n];
      w[ITC_B_WAKE]   = wake_reg[n];
      w[ITC_B_DEAD]   = dead_reg[n];
      w[ITC_B_ACTIVE] = active_reg[n];
      w[ITC_B_EVT_HI:ITC_B_EVT_LO] = evt_reg[n];
      ctl_word = w;
   endfunction

   // both views read back the same word; unmapped reads give zero
   // a process, so changes of the arrays inside ctl_word wake it
   always_comb
   begin
      rdata_next = ITC_ZERO32;
      if (i_rd)
      begin
         if (set_hit || clr_hit)
            rdata_next = ctl_word(acc_ctx);
         else if (stat_hit)
            rdata_next = {16'h0000, stat_reg};
         else if (mask_hit)
            rdata_next = {16'h0000, mask_reg};
      end
   end

   always_comb
   begin
      logic sw_set;
      logic sw_clr;
      logic go;
      logic [15:0] st_set;
      sw_set = 1'b0;
      sw_clr = 1'b0;
      go     = 1'b0;
      st_set = 16'h0000;
      stat_next = stat_reg;
      for (int n = 0; n < ITC_NCTX; n++)
      begin
         sw_set = i_wr && set_hit && (acc_ctx == itc_idx_t'(n));
         sw_clr = i_wr && clr_hit && (acc_ctx == itc_idx_t'(n));
         soc_en_next[n] = soc_en_reg[n];
         tgt_next[n]    = tgt_reg[n];
         run_next[n]    = run_reg[n];
         wake_next[n]   = wake_reg[n];
         dead_next[n]   = dead_reg[n];
         paused_next[n] = paused_reg[n];
         hold_next[n]   = hold_reg[n];
         evt_next[n]    = evt_reg[n];
         // software set/clear, ones only
         if (sw_set)
         begin
            soc_en_next[n] = soc_en_reg[n] | i_wdata[ITC_B_SOC_EN];
            tgt_next[n] = tgt_reg[n] |
                          i_wdata[ITC_B_TGT_HI:ITC_B_TGT_LO];
            run_next[n]  = run_reg[n] | i_wdata[ITC_B_RUN];
            wake_next[n] = wake_reg[n] | i_wdata[ITC_B_WAKE];
         end
         if (sw_clr)
         begin
            soc_en_next[n] = soc_en_reg[n] & ~i_wdata[ITC_B_SOC_EN];
            tgt_next[n] = tgt_reg[n] &
                          ~i_wdata[ITC_B_TGT_HI:ITC_B_TGT_LO];
            run_next[n] = run_reg[n] & ~i_wdata[ITC_B_RUN];
         end
         // fetch clears wake unless software sets it in this cycle
         if (i_desc_fetch[n] && !(sw_set && i_wdata[ITC_B_WAKE]))
            wake_next[n] = 1'b0;
         // fresh start from run, or wake resumes a paused list
         if (run_next[n] && !run_reg[n])
            paused_next[n] = 1'b0;
         if (i_list_done[n] && active_reg[n])
            paused_next[n] = 1'b1;
         if (wake_next[n] && !wake_reg[n])
            paused_next[n] = 1'b0;
         if (!run_next[n])
            dead_next[n] = 1'b0;
         if (i_fatal_err[n] && run_reg[n])
            dead_next[n] = 1'b1;
         active_next[n] = run_next[n] && !dead_next[n] &&
                          !paused_next[n];
         go = active_next[n] && !active_reg[n];
         // enable drops on activation; hold keeps the tx gate closed
         if (go && soc_en_next[n])
         begin
            hold_next[n]   = 1'b1;
            soc_en_next[n] = 1'b0;
         end
         // matched cycle opens transmission, fetch already allowed
         if (hold_reg[n] && tgt_match[n])
            hold_next[n] = 1'b0;
         if (!active_next[n])
            hold_next[n] = 1'b0;
         if (i_evt_valid && i_evt_ctx == itc_idx_t'(n))
         begin
            evt_next[n] = i_evt_code;
            st_set[ITC_ST_CMP_LSB + n] = 1'b1;
         end
         if (dead_next[n] && !dead_reg[n])
            st_set[ITC_ST_DEAD_LSB + n] = 1'b1;
      end
      // write-one-to-clear; a new event in the same cycle stays set
      if (i_wr && stat_hit)
         stat_next = stat_reg & ~i_wdata[15:0];
      stat_next = stat_next | st_set;
   end

   assign mask_next = (i_wr && mask_hit) ? i_wdata[15:0] : mask_reg;

   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         stat_reg  <= ITC_IRQ_RST;
         mask_reg  <= ITC_IRQ_RST;
         rdata_reg <= ITC_ZERO32;
      end
      else if (i_soft_rst)
      begin
         stat_reg  <= ITC_IRQ_RST;
         mask_reg  <= ITC_IRQ_RST;
         rdata_reg <= ITC_ZERO32;
      end
      else
      begin
         stat_reg  <= stat_next;
         mask_reg  <= mask_next;
         rdata_reg <= rdata_next;
      end
   end

   // reset paths are the only hardware clear of run
   always_ff @(posedge i_mclk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         for (int n = 0; n < ITC_NCTX; n++)
         begin
            soc_en_reg[n] <= 1'b0;
            tgt_reg[n]    <= ITC_TGT_RST;
            run_reg[n]    <= 1'b0;
            wake_reg[n]   <= 1'b0;
            dead_reg[n]   <= 1'b0;
            active_reg[n] <= 1'b0;
            paused_reg[n] <= 1'b0;
            hold_reg[n]   <= 1'b0;
            evt_reg[n]    <= ITC_EVT_RST;
         end
      end
      else if (i_soft_rst)
      begin
         for (int n = 0; n < ITC_NCTX; n++)
         begin
            soc_en_reg[n] <= 1'b0;
            tgt_reg[n]    <= ITC_TGT_RST;
            run_reg[n]    <= 1'b0;
            wake_reg[n]   <= 1'b0;
            dead_reg[n]   <= 1'b0;
            active_reg[n] <= 1'b0;
            paused_reg[n] <= 1'b0;
            hold_reg[n]   <= 1'b0;
            evt_reg[n]    <= ITC_EVT_RST;
         end
      end
      else
      begin
         for (int n = 0; n < ITC_NCTX; n++)
         begin
            soc_en_reg[n] <= soc_en_next[n];
            tgt_reg[n]    <= tgt_next[n];
            run_reg[n]    <= run_next[n];
            wake_reg[n]   <= wake_next[n];
            dead_reg[n]   <= dead_next[n];
            active_reg[n] <= active_next[n];
            paused_reg[n] <= paused_next[n];
            hold_reg[n]   <= hold_next[n];
            evt_reg[n]    <= evt_next[n];
         end
      end
   end

   always_comb
   begin
      for (int n = 0; n < ITC_NCTX; n++)
      begin
         o_fetch_en[n] = active_reg[n];
         o_tx_en[n]    = active_reg[n] && !hold_reg[n];
      end
   end

   assign o_rdata = rdata_reg;
   assign o_irq   = |(stat_reg & mask_reg);

endmodule // itc_ctrl

// ===== shared/itc_pkg.sv
// Purpose: constants for the isochronous transmit context control block
// Assumes: 12-bit byte addresses on the register port, 32-bit data
// Notes:   status and mask words sit above the context control words
package itc_pkg;
   localparam int ITC_NCTX = 8;
   localparam int ITC_AW   = 12;
   localparam int ITC_DW   = 32;

   // context n: set view at base + stride*n, clear view at +4
   localparam logic [11:0] ITC_SET_BASE = 12'h200;
   localparam logic [11:0] ITC_CLR_BASE = 12'h204;
   localparam logic [11:0] ITC_CTX_MASK = 12'hF8F;
   localparam int          ITC_CTX_LSB  = 4;
   localparam int          ITC_CTX_W    = 3;

   localparam logic [11:0] ITC_IRQ_STAT = 12'h300;
   localparam logic [11:0] ITC_IRQ_MASK = 12'h304;

   // control word fields
   localparam int ITC_B_SOC_EN  = 31;
   localparam int ITC_B_TGT_HI  = 30;
   localparam int ITC_B_TGT_LO  = 16;
   localparam int ITC_B_RUN     = 15;
   localparam int ITC_B_WAKE    = 12;
   localparam int ITC_B_DEAD    = 11;
   localparam int ITC_B_ACTIVE  = 10;
   localparam int ITC_B_EVT_HI  = 4;
   localparam int ITC_B_EVT_LO  = 0;
   localparam int ITC_TGT_W     = 15;
   localparam int ITC_EVT_W     = 5;
   localparam int ITC_SEC_W     = 2;
   localparam int ITC_CNT_W     = 13;

   // status word: [15:8] dead events, [7:0] completion events
   localparam int ITC_ST_DEAD_LSB = 8;
   localparam int ITC_ST_CMP_LSB  = 0;

   localparam logic [31:0] ITC_ZERO32 = 32'h0000_0000;
   localparam logic [14:0] ITC_TGT_RST = 15'h0000;
   localparam logic [4:0]  ITC_EVT_RST = 5'h00;
   localparam logic [15:0] ITC_IRQ_RST = 16'h0000;

   typedef logic [ITC_CTX_W-1:0] itc_idx_t;
endpackage

// ===== testbench/itc_ctrl_properties.sv
// Purpose: port-level checks for the transmit context control block
// Assumes: single clock domain, async reset active low
// Notes:   bound to every itc_ctrl instance
`timescale 1ns/1ps
module itc_ctrl_chk
   import itc_pkg::*;
(
   input wire logic                i_mclk,
   input wire logic                i_arst_n,
   input wire logic                i_soft_rst,
   input wire logic [ITC_AW-1:0]   i_addr,
   input wire logic                i_wr,
   input wire logic                i_rd,
   input wire logic [ITC_DW-1:0]   o_rdata,
   input wire logic                i_cs_valid,
   input wire logic [ITC_NCTX-1:0] i_list_done,
   input wire logic [ITC_NCTX-1:0] i_fatal_err,
   input wire logic                i_evt_valid,
   input wire logic [ITC_NCTX-1:0] o_fetch_en,
   input wire logic [ITC_NCTX-1:0] o_tx_en,
   input wire logic                o_irq
);
   default clocking dcb @(posedge i_mclk); endclocking
   default disable iff (!i_arst_n);

   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == '0)
      else $error("read data not zero outside read cycle");
   a_unmapped_zero: assert property (i_rd && i_addr[11:8] == 4'h2 && i_addr[7]
      |=> o_rdata == '0) else $error("unmapped read not zero");
   a_reserved_bits_zero: assert property (i_rd && i_addr[11:8] == 4'h2
      |=> (o_rdata & 32'h0000_63E0) == '0) else $error("reserved bits set");
   a_tx_needs_fetch: assert property ((o_tx_en & ~o_fetch_en) == '0)
      else $error("transmit enabled on idle context");
   a_tx_rise_cause: assert property ((o_tx_en & ~$past(o_tx_en)) != '0
      |-> $past(i_cs_valid) || $past(i_wr)) else $error("tx rose uncaused");
   a_fetch_rise_cause: assert property ((o_fetch_en & ~$past(o_fetch_en)) != '0
      |-> $past(i_wr)) else $error("fetch rose without write");
   a_fetch_drop_cause: assert property ((~o_fetch_en & $past(o_fetch_en)) != '0
      |-> $past(i_wr || i_soft_rst || i_list_done != '0 ||
      i_fatal_err != '0)) else $error("fetch dropped uncaused");
   a_irq_rise_cause: assert property ($rose(o_irq) |->
      $past(i_wr || i_evt_valid || i_fatal_err != '0) ||
      $past(i_wr || i_evt_valid || i_fatal_err != '0, 2))
      else $error("interrupt rose uncaused");
   a_soft_clears: assert property (i_soft_rst |=> o_fetch_en == '0 &&
      o_tx_en == '0 ##1 !o_irq) else $error("soft reset left state");
endmodule // itc_ctrl_chk

bind itc_ctrl itc_ctrl_chk u_chk (.i_mclk, .i_arst_n, .i_soft_rst, .i_addr,
   .i_wr, .i_rd, .o_rdata, .i_cs_valid, .i_list_done, .i_fatal_err,
   .i_evt_valid, .o_fetch_en, .o_tx_en, .o_irq);

// ===== testbench/itc_ctrl_tb.sv
// Purpose: self-checking bench for the transmit context control block
// Assumes: register reads answer one cycle after the strobe
// Notes:   table rows first, then sequenced context cases
`timescale 1ns/1ps
module itc_ctrl_tb;
   import itc_pkg::*;
   typedef struct packed {
      logic [11:0] wa;
      logic [31:0] wd;
      logic [11:0] ra;
      logic [31:0] ex;
   } itc_row_t;
   logic        i_mclk, i_arst_n, i_soft_rst, i_wr, i_rd, i_cs_valid;
   logic        i_evt_valid, o_irq;
   logic [11:0] i_addr;
   logic [31:0] i_wdata, o_rdata;
   logic [6:0]  i_cs_seconds;
   logic [12:0] i_cs_count;
   logic [7:0]  i_desc_fetch, i_list_done, i_fatal_err, o_fetch_en, o_tx_en;
   logic [2:0]  i_evt_ctx;
   logic [4:0]  i_evt_code;
   int          num_errors = 0;
   int          total_checks = 0;
   itc_row_t    rows [8] = '{
      '{12'h200, 32'hFFFF_0000, 12'h204, 32'hFFFF_0000},
      '{12'h204, 32'h8000_0000, 12'h200, 32'h7FFF_0000},
      '{12'h270, 32'h0000_1000, 12'h274, 32'h0000_1000},
      '{12'h230, 32'hFFFF_FFFF, 12'h234, 32'h7FFF_9400},
      '{12'h234, 32'h7FFF_0000, 12'h230, 32'h0000_9400},
      '{12'h280, 32'hFFFF_FFFF, 12'h208, 32'h0000_0000},
      '{12'h304, 32'hFFFF_FFFF, 12'h304, 32'h0000_FFFF},
      '{12'h208, 32'hFFFF_FFFF, 12'h280, 32'h0000_0000}};

   itc_ctrl u_dut (.i_mclk, .i_arst_n, .i_soft_rst, .i_addr, .i_wdata, .i_wr,
      .i_rd, .o_rdata, .i_cs_valid, .i_cs_seconds, .i_cs_count, .i_desc_fetch,
      .i_list_done, .i_fatal_err, .i_evt_valid, .i_evt_ctx, .i_evt_code,
      .o_fetch_en, .o_tx_en, .o_irq);

   initial
   begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // outputs and irq share the word compare, zero extended
   task automatic chk_bits(input logic [7:0] got, input logic [7:0] exp);
      chk_word({24'h00_0000, got}, {24'h00_0000, exp});
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] ex);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      chk_word(o_rdata, ex);
   endtask

   // one-cycle pulse on {evt_valid, desc_fetch, list_done, fatal_err}
   task automatic ev(input logic [24:0] m);
      @(posedge i_mclk);
      {i_evt_valid, i_desc_fetch, i_list_done, i_fatal_err} <= m;
      @(posedge i_mclk);
      {i_evt_valid, i_desc_fetch, i_list_done, i_fatal_err} <= '0;
      #1;
   endtask

   task automatic cs(input logic [6:0] s, input logic [12:0] c);
      @(posedge i_mclk);
      i_cs_valid <= 1'b1;
      i_cs_seconds <= s;
      i_cs_count <= c;
      @(posedge i_mclk);
      i_cs_valid <= 1'b0;
      #1;
   endtask

   task automatic settle;
      @(posedge i_mclk);
      #1;
   endtask

   task automatic stop_test;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      {i_arst_n, i_soft_rst, i_wr, i_rd, i_cs_valid, i_evt_valid} = '0;
      {i_addr, i_wdata, i_cs_seconds, i_cs_count, i_evt_ctx} = '0;
      {i_desc_fetch, i_list_done, i_fatal_err, i_evt_code} = '0;
      repeat (4) @(posedge i_mclk);
      i_arst_n <= 1'b1;
      #1;
      chk_bits(o_fetch_en | o_tx_en | {7'h00, o_irq}, 8'h00);
      foreach (rows[i])
      begin
         wr(rows[i].wa, rows[i].wd);
         rd(rows[i].ra, rows[i].ex);
      end
      ev(25'h008_0000);
      rd(12'h230, 32'h0000_8400);
      ev(25'h000_0800);
      chk_bits(o_fetch_en, 8'h00);
      wr(12'h230, 32'h0000_1000);
      chk_bits(o_fetch_en, 8'h08);
      // ctx1 waits for seconds[1:0]=2, count=5
      wr(12'h210, 32'hC005_8000);
      chk_bits(o_fetch_en, 8'h0A);
      chk_bits(o_tx_en, 8'h08);
      cs(7'h06, 13'h0004);
      chk_bits(o_tx_en, 8'h08);
      cs(7'h05, 13'h0005);
      chk_bits(o_tx_en, 8'h08);
      cs(7'h7E, 13'h0005);
      chk_bits(o_tx_en, 8'h0A);
      rd(12'h210, 32'h4005_8400);
      ev(25'h000_0002);
      chk_bits(o_fetch_en | o_tx_en, 8'h08);
      settle();
      chk_bits({7'h00, o_irq}, 8'h01);
      rd(12'h300, 32'h0000_0200);
      rd(12'h210, 32'h4005_8800);
      wr(12'h214, 32'h0000_8000);
      rd(12'h210, 32'h4005_0000);
      wr(12'h300, 32'h0000_0200);
      rd(12'h300, 32'h0000_0000);
      chk_bits({7'h00, o_irq}, 8'h00);
      wr(12'h304, 32'h0000_0000);
      @(posedge i_mclk);
      i_evt_ctx <= 3'h2;
      i_evt_code <= 5'h11;
      ev(25'h100_0000);
      rd(12'h220, 32'h0000_0011);
      chk_bits({7'h00, o_irq}, 8'h00);
      wr(12'h304, 32'h0000_0004);
      settle();
      chk_bits({7'h00, o_irq}, 8'h01);
      // clear and a new event in one cycle: the event must stay
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= 12'h300;
      i_wdata <= 32'h0000_0004;
      i_evt_valid <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
      i_evt_valid <= 1'b0;
      rd(12'h300, 32'h0000_0004);
      @(posedge i_mclk);
      i_soft_rst <= 1'b1;
      @(posedge i_mclk);
      i_soft_rst <= 1'b0;
      settle();
      chk_bits(o_fetch_en | {7'h00, o_irq}, 8'h00);
      rd(12'h230, 32'h0000_0000);
      stop_test();
   end

   // whole sequence needs well under 400 cycles
   initial
   begin
      repeat (5000) @(posedge i_mclk);
      num_errors++;
      stop_test();
   end
endmodule // itc_ctrl_tb
